/* dv/cgs_timing_model.sv */
`timescale 1ns/1ps
module cgs_timing_model (
   input  wire logic       clk,
   input  wire logic       run,
   output logic      [3:0] dot_count,
   output logic      [6:0] char_count,
   output logic      [3:0] row_count,
   output logic      [4:0] line_count,
   output logic            glyph_addr_load_n,
   output logic      [7:0] char_code,
   output logic            parity_ok_n,
   output logic            fetch,
   output logic      [3:0] fetch_seg
);
   logic [7:0] codes [80];
   logic       bad   [80];
   logic       acc;
   int         idx;
   initial begin
      {dot_count, row_count, char_count, line_count} = {8'h07, 7'h5A, 5'h19};
      {glyph_addr_load_n, parity_ok_n, fetch, char_code, fetch_seg} = {3'b110, 12'h000};
   end
   always @(posedge clk) begin
      #1;
      if (run) begin
         dot_count = (dot_count == 4'h8) ? 4'h0 : dot_count + 4'h1;
         if (dot_count == 4'h0) begin
            char_count = (char_count == 7'h60) ? 7'h00 : char_count + 7'h01;
            if (char_count == 7'h00) begin
               // Start line is cut short after row 7
               row_count = (row_count == ((line_count == 5'h19) ? 4'h7 : 4'hC)) ? 4'h0
                           : row_count + 4'h1;
               if (row_count == 4'h0)
                  line_count = (line_count == 5'h19) ? 5'h00 : line_count + 5'h01;
            end
         end
      end
      // New text only in blank rows, so rows 0-10 of a line see the same codes
      if (run && char_count == 7'h5B && dot_count == 4'h0 &&
          (row_count > 4'hA || line_count == 5'h19)) begin
         foreach (codes[i]) begin
            codes[i] = 8'($urandom);
            bad[i] = ($urandom_range(7) == 0);
         end
      end
      // Two characters ahead: 95 and 96 fetch characters 0 and 1 of the next row
      acc = (char_count >= 7'h5F) ? ((line_count == 5'h19 && row_count == 4'h7) ||
            (line_count < 5'h18 && row_count < 4'hA))
            : (char_count < 7'h4E && line_count < 5'h18 && row_count < 4'hB);
      idx = (char_count == 7'h5F) ? 0 : (char_count == 7'h60) ? 1 : int'(char_count) + 2;
      fetch = 1'b0;
      glyph_addr_load_n = 1'b1;
      // Released data lines toggle so a stale value is never mistaken for a fresh one
      if (dot_count inside {[4'h1:4'h5]})
         {char_code, parity_ok_n} = ~{char_code, parity_ok_n};
      if (acc && dot_count == 4'h6) begin
         char_code = codes[idx];
         parity_ok_n = ~bad[idx];
      end
      if (acc && dot_count == 4'h7) begin
         glyph_addr_load_n = 1'b0;
         fetch = 1'b1;
         fetch_seg = (char_count < 7'h5F) ? row_count
                     : (line_count == 5'h19) ? 4'h0 : row_count + 4'h1;
      end
   end
endmodule

/* dv/char_generator_serializer_bench.sv */
`timescale 1ns/1ps
module char_generator_serializer_bench;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       run = 1'b0;
   logic       we = 1'b0;
   logic       we_low = 1'b0;
   logic [5:0] we_char = 6'h00;
   logic [3:0] we_seg = 4'h0;
   logic [6:0] we_data = 7'h00;
   logic [3:0] dot, row, fseg;
   logic [6:0] chr, glyph, word, glyph_prev;
   logic [4:0] line;
   logic [7:0] code;
   logic       ld_n, pok_n, fetch, up_step, lo_step, s_ld, s_sh, dot_out;
   logic [6:0] pat [2][64][9];
   logic [6:0] expq [$];
   int         nbits = 7;
   int         n_ld, n_sh, n_up, n_lo, n_up10, err_total, checks, cyc;
   always #10 clk = ~clk;
   cgs_timing_model i_model (.clk(clk), .run(run), .dot_count(dot), .char_count(chr),
      .row_count(row), .line_count(line), .glyph_addr_load_n(ld_n), .char_code(code),
      .parity_ok_n(pok_n), .fetch(fetch), .fetch_seg(fseg));
   cgs_char_generator_serializer i_dut (.clk(clk), .rstn(rstn), .dot_count(dot),
      .char_count(chr), .row_count(row), .line_count(line), .glyph_addr_load_n(ld_n),
      .char_code(code), .parity_ok_n(pok_n), .hex_mode(1'b0), .glyph_we(we),
      .glyph_we_lower(we_low), .glyph_we_char(we_char), .glyph_we_seg(we_seg),
      .glyph_we_data(we_data), .upper_segment_step(up_step), .lower_segment_step(lo_step),
      .shifter_load(s_ld), .shifter_shift(s_sh), .video_dot(dot_out), .glyph_out(glyph));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Segment table index folds modulo 9, so rows 9 and 10 reuse segments 0 and 1
   function automatic logic [6:0] exp_glyph(logic [7:0] c, logic p_n, logic [3:0] s);
      return pat[c[6] ? 0 : 1][c[5:0]][int'(s) % 9] ^ (p_n ? 7'h00 : 7'h7F);
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         finish_test();
      end
      if (run) begin
         if (fetch)
            expq.push_back(exp_glyph(code, pok_n, fseg));
         if (s_ld) begin
            n_ld++;
            nbits = 0;
            if (expq.size() > 0)
               check("glyph out", expq[0], glyph_prev);
         end
         if (s_sh) begin
            n_sh++;
            if (nbits < 7) begin
               word = {word[5:0], dot_out};
               nbits++;
               if (nbits == 7 && expq.size() == 0)
                  check("glyph queue", 1, 0);
               else if (nbits == 7)
                  check("glyph dots", expq.pop_front(), word);
            end
         end
         if (up_step || lo_step)
            check("step char", 7'h58, chr);
         n_up += up_step;
         n_lo += lo_step;
         n_up10 += (up_step && row == 4'hA);
      end
      glyph_prev = glyph;
   end
   initial begin
      void'($urandom(32'h478A5D08));
      repeat (20) @(posedge clk);
      check("reset outputs", 0, {up_step, lo_step, s_ld, s_sh, dot_out, glyph});
      #1 rstn = 1'b1;
      $display("test reset done");
      for (int l = 0; l < 2; l++) begin
         for (int c = 0; c < 64; c++) begin
            for (int s = 0; s < 9; s++) begin
               @(posedge clk);
               #1;
               {we, we_low, we_char, we_seg, we_data} = {1'b1, 1'(l), 6'(c), 4'(s), 7'($urandom)};
               pat[l][c][s] = we_data;
            end
         end
      end
      @(posedge clk);
      #1 we = 1'b0;
      $display("test table done");
      @(posedge clk);
      #1 run = 1'b1;
      while (line !== 5'h01)
         @(posedge clk);
      check("loads", 891, n_ld);
      check("shifts", 7040, n_sh);
      check("upper steps", 16, n_up);
      check("lower steps", 16, n_lo);
      check("row 10 steps", 6, n_up10);
      check("glyphs left", 0, expq.size());
      $display("test stream done");
      finish_test();
   end
endmodule

/* rtl/cgs_char_generator_serializer.sv */
`timescale 1ns/1ps
module cgs_char_generator_serializer (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [3:0] dot_count,
   input  wire logic [6:0] char_count,
   input  wire logic [3:0] row_count,
   input  wire logic [4:0] line_count,
   input  wire logic       glyph_addr_load_n,
   input  wire logic [7:0] char_code,
   input  wire logic       parity_ok_n,
   input  wire logic       hex_mode,
   input  wire logic       glyph_we,
   input  wire logic       glyph_we_lower,
   input  wire logic [5:0] glyph_we_char,
   input  wire logic [3:0] glyph_we_seg,
   input  wire logic [6:0] glyph_we_data,
   output logic            upper_segment_step,
   output logic            lower_segment_step,
   output logic            shifter_load,
   output logic            shifter_shift,
   output logic            video_dot,
   output logic [6:0]      glyph_out
);
   // Pattern tables; loadable so no vendor font is baked in
   logic [6:0] upper_rom [cgs_pkg::GLYPHS*cgs_pkg::SEGS];
   logic [6:0] lower_rom [cgs_pkg::GLYPHS*cgs_pkg::SEGS];
   logic [6:0] hex_rom   [cgs_pkg::GLYPHS*cgs_pkg::SEGS];

   logic [7:0]             char_q;
   logic                   par_q;
   logic                   load_n_q;
   logic [3:0]             upper_seg_q;
   logic [3:0]             lower_seg_q;
   logic [3:0]             burst_q;
   cgs_pkg::cgs_step_type  step_q;
   logic [7:0]             shreg_q;
   logic                   up_step_q;
   logic                   lo_step_q;
   logic                   ld_q;
   logic                   sh_q;
   logic                   dot_q;
   logic [6:0]             gout_q;
   logic                   active_q;
   logic [6:0]             glyph_d;
   logic [6:0]             fifo_data;
   logic                   fifo_valid;
   logic                   fifo_in_ready;
   logic                   load_now;
   logic                   shift_now;
   logic                   step_time;

   // Counter runs through 16 steps per line, 8 on line 25; rows 9 and 10 fold back onto segments 0 and 1
   function automatic logic [9:0] tbl_idx(input logic [5:0] ch, input logic [3:0] seg);
      logic [3:0] s;
      s = (seg >= 4'(cgs_pkg::SEGS)) ? seg - 4'(cgs_pkg::SEGS) : seg;
      tbl_idx = 10'(ch) * 10'(cgs_pkg::SEGS) + 10'(s);
   endfunction

   always_ff @(posedge clk) begin
      if (glyph_we) begin
         if (glyph_we_lower) begin
            lower_rom[tbl_idx(glyph_we_char, glyph_we_seg)] <= glyph_we_data;
         end else begin
            upper_rom[tbl_idx(glyph_we_char, glyph_we_seg)] <= glyph_we_data;
         end
         hex_rom[tbl_idx(glyph_we_char, glyph_we_seg)] <= glyph_we_data;
      end
   end

   // Strobe is active low; capture when it returns high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         load_n_q <= 1'b1;
         char_q   <= cgs_pkg::CHAR_RESET;
         par_q    <= cgs_pkg::PARITY_OK;
      end else begin
         load_n_q <= glyph_addr_load_n;
         if (glyph_addr_load_n && !load_n_q) begin
            char_q <= char_code;
            par_q  <= parity_ok_n;
         end
      end
   end

   // Generator select and complement
   always_comb begin
      if (char_q[6]) begin
         glyph_d = upper_rom[tbl_idx(char_q[5:0], upper_seg_q)];
      end else if (hex_mode) begin
         glyph_d = hex_rom[tbl_idx({char_q[7], char_q[4:0]}, lower_seg_q)];
      end else begin
         glyph_d = lower_rom[tbl_idx(char_q[5:0], lower_seg_q)];
      end
      if (!par_q) begin
         glyph_d = ~glyph_d;
      end
   end

   // Display window: opens at char 96 row 7 line 25, at char 96 of rows 0-9 on other lines, or at char 0; closes at 80
   assign load_now  = (dot_count == cgs_pkg::DOT_LOAD) &&
                      ((char_count <= cgs_pkg::CT_LAST_VALID &&
                        row_count <= cgs_pkg::ROW_LAST_CHAR) ||
                       (char_count == cgs_pkg::CT_FIRST_LOAD &&
                        row_count == cgs_pkg::ROW_FIRST_LD &&
                        line_count == cgs_pkg::LINE_PRE) ||
                       (char_count == cgs_pkg::CT_FIRST_LOAD &&
                        row_count < cgs_pkg::ROW_LAST_CHAR &&
                        line_count != cgs_pkg::LINE_PRE));
   assign shift_now = active_q && (dot_count <= cgs_pkg::DOT_LAST) &&
                      (char_count <= cgs_pkg::CT_LAST_VALID);
   assign step_time = (char_count == cgs_pkg::CT_STEP) &&
                      (dot_count == cgs_pkg::DOT_SHIFT0) &&
                      (row_count <= cgs_pkg::ROW_LAST_CHAR);

   // Short elastic buffer between generator output and shifter
   cgs_fifo #(
      .WIDTH(cgs_pkg::GLYPH_W),
      .DEPTH(cgs_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rstn     (rstn),
      .in_data  (glyph_d),
      .in_valid (load_now),
      .in_ready (fifo_in_ready),
      .out_data (fifo_data),
      .out_valid(fifo_valid),
      .out_ready(1'b1)
   );

   // Shifter
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         shreg_q  <= '0;
         ld_q     <= 1'b0;
         sh_q     <= 1'b0;
         dot_q    <= 1'b0;
         gout_q   <= '0;
         active_q <= 1'b0;
      end else begin
         ld_q   <= fifo_valid;
         sh_q   <= shift_now && !fifo_valid;
         gout_q <= glyph_d;
         if (fifo_valid) begin
            shreg_q  <= {fifo_data, 1'b0};
            active_q <= 1'b1;
         end else if (shift_now) begin
            shreg_q <= {shreg_q[6:0], 1'b0};
            dot_q   <= shreg_q[7];
         end else begin
            dot_q <= 1'b0;
         end
         if (char_count > cgs_pkg::CT_LAST_VALID && char_count < cgs_pkg::CT_FIRST_LOAD) begin
            active_q <= 1'b0;
         end
      end
   end

   // Segment stepping
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         step_q      <= cgs_pkg::STEP_IDLE;
         burst_q     <= '0;
         up_step_q   <= 1'b0;
         lo_step_q   <= 1'b0;
         upper_seg_q <= cgs_pkg::SEG_RESET;
         lower_seg_q <= cgs_pkg::SEG_RESET;
      end else begin
         up_step_q <= 1'b0;
         lo_step_q <= 1'b0;
         case (step_q)
            cgs_pkg::STEP_IDLE: begin
               if (step_time) begin
                  step_q  <= (row_count == cgs_pkg::ROW_LAST_CHAR) ?
                             cgs_pkg::STEP_BURST : cgs_pkg::STEP_ONE;
                  burst_q <= cgs_pkg::RESET_STEPS;
               end
            end
            cgs_pkg::STEP_ONE: begin
               up_step_q <= 1'b1;
               lo_step_q <= 1'b1;
               step_q    <= cgs_pkg::STEP_IDLE;
            end
            cgs_pkg::STEP_BURST: begin
               up_step_q <= 1'b1;
               lo_step_q <= 1'b1;
               if (burst_q == 4'h0) begin
                  step_q <= cgs_pkg::STEP_IDLE;
               end
               burst_q <= burst_q - 4'h1;
            end
            default: step_q <= cgs_pkg::STEP_IDLE;
         endcase
         if (up_step_q) begin
            upper_seg_q <= upper_seg_q + 4'h1;
         end
         if (lo_step_q) begin
            lower_seg_q <= lower_seg_q + 4'h1;
         end
      end
   end

   assign upper_segment_step = up_step_q;
   assign lower_segment_step = lo_step_q;
   assign shifter_load       = ld_q;
   assign shifter_shift      = sh_q;
   assign video_dot          = dot_q;
   assign glyph_out          = gout_q;

   AST_STEP_ONE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
      (step_q == cgs_pkg::STEP_ONE) |=> up_step_q ##1 !up_step_q)
      else $error("single segment step not one pulse");
   AST_BURST_SIX: assert property (@(posedge clk) disable iff (!rstn)
      (step_q == cgs_pkg::STEP_IDLE && step_time && row_count == cgs_pkg::ROW_LAST_CHAR)
      |=> ##1 up_step_q [*6] ##1 !up_step_q)
      else $error("row 10 step burst not six pulses");
   AST_SEG_WRAP: assert property (@(posedge clk) disable iff (!rstn)
      (step_q == cgs_pkg::STEP_BURST && burst_q == 4'h0) |=> ##1 upper_seg_q == 4'h0)
      else $error("segment counter not back to zero");
   AST_NO_STRAY_STEP: assert property (@(posedge clk) disable iff (!rstn)
      (step_q == cgs_pkg::STEP_IDLE) |=> !up_step_q || $past(step_q) != cgs_pkg::STEP_IDLE)
      else $error("segment step outside step window");
   AST_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
      (glyph_addr_load_n && !load_n_q) |=> char_q == $past(char_code))
      else $error("character not captured on strobe release");
   AST_COMPLEMENT: assert property (@(posedge clk) disable iff (!rstn)
      (!par_q && char_q[6]) |-> glyph_d == ~upper_rom[tbl_idx(char_q[5:0], upper_seg_q)])
      else $error("parity error did not invert output");
   AST_LOAD_TO_SHIFTER: assert property (@(posedge clk) disable iff (!rstn)
      load_now |=> ##1 (ld_q && shreg_q[7:1] == $past(glyph_d, 2)))
      else $error("shifter did not load glyph");
   AST_NO_SHIFT_DEAD: assert property (@(posedge clk) disable iff (!rstn)
      (char_count > cgs_pkg::CT_LAST_VALID) |=> !sh_q)
      else $error("shift during dead time");
   AST_UPPER_SEL: assert property (@(posedge clk) disable iff (!rstn)
      (char_q[6] && par_q) |-> glyph_d == upper_rom[tbl_idx(char_q[5:0], upper_seg_q)])
      else $error("upper generator not selected");
endmodule

/* rtl/cgs_fifo.sv */
`timescale 1ns/1ps
module cgs_fifo #(
   parameter int WIDTH = 7,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* rtl/cgs_pkg.sv */
package cgs_pkg;
   localparam int          CHAR_W        = 8;
   localparam int          GLYPH_W       = 7;
   localparam int          SHIFT_W       = 8;
   localparam int          GLYPHS        = 64;
   localparam int          SEGS          = 9;
   localparam int          TABLE_BITS    = GLYPHS * SEGS * GLYPH_W;
   localparam logic [3:0]  DOT_LOAD      = 4'h8;
   localparam logic [3:0]  DOT_SHIFT0    = 4'h0;
   localparam logic [3:0]  DOT_LAST      = 4'h8;
   localparam logic [6:0]  CT_STEP       = 7'h58;
   localparam logic [6:0]  CT_LAST_VALID = 7'h4F;
   localparam logic [6:0]  CT_FIRST_LOAD = 7'h60;
   localparam logic [3:0]  ROW_LAST_CHAR = 4'hA;
   localparam logic [3:0]  ROW_FIRST_LD  = 4'h7;
   localparam logic [4:0]  LINE_PRE      = 5'h19;
   localparam logic [3:0]  RESET_STEPS   = 4'h5;
   localparam logic [3:0]  SEG_RESET     = 4'h0;
   localparam logic [7:0]  CHAR_RESET    = 8'h00;
   localparam int          FIFO_DEPTH    = 8;
   localparam logic        PARITY_OK     = 1'b1;
   typedef enum logic [1:0] {
      STEP_IDLE  = 2'b00,
      STEP_ONE   = 2'b01,
      STEP_BURST = 2'b10
   } cgs_step_type;
endpackage
